/* File: design/rx_crc_parity_check.sv */
// Receive CRC and parity check with its configuration register and interrupt logic
//
// Contract
// - A 16-bit software custom CRC seed is held, used for seed selection 111b.
// - Parity type 0 checks even parity, 1 checks odd parity.
// - Parity enabled: one parity bit per byte, stripped, checked, error flagged, reception continues.
// - Auto detection of type A sets parity enable and parity type.
// - Bits after a collision are cleared at option 0, kept at option 1.
// - Alignment field places the first received bit; later bits follow in sequence.
// - Seed selection maps to 0000h,6363h,A671h,FFFFh,0012h,E012h,reserved,custom seed.
// - With the 5-bit CRC only the seed's low byte initialises it.
// - Detector loads seed selection 001b for A, 011b for B, 000b for JIS.
// - CRC length bit: 0 selects 16-bit CRC (reset), 1 selects 5-bit.
// - Inversion bit 1 expects residue F0B8h with the 16-bit CRC (00h with the 5-bit CRC); 0 compares uninverted.
// - Detector clears inversion bit for A and JIS, sets it for B.
// - CRC enable set checks each frame's CRC; clear means no check.
// - Detector sets CRC enable for type B or JIS at 212 or 424 kbit/s.
// - Bits 15 to 12 of the configuration are read-only zero.
// - Parity or CRC mismatch sets the integrity-error flag.
// - The integrity-error flag clears when the next reception starts.
`timescale 1ns/100ps
module rx_crc_parity_check (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [rx_check_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [rx_check_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [rx_check_pkg::DATA_W-1:0] reg_rdata,
	input wire logic rx_start,
	input wire logic rx_end,
	input wire rx_check_pkg::rx_bit_s rx_bit,
	input wire logic md_valid,
	input wire rx_check_pkg::md_mode_e md_mode,
	output rx_check_pkg::rx_byte_s rx_byte,
	output logic integrity_error,
	output logic crc_error,
	output logic irq
);
	import rx_check_pkg::*;

	typedef struct packed {
		cfg_s cfg;
		cfg_s snap;
		logic auto_detect_en;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic [DATA_W-1:0] rdata;
		frame_e frame;
		logic coll_seen;
		logic integrity;
		logic crc_err;
		logic par_err_seen;
	} top_state_s;

	top_state_s st_r;
	top_state_s st_nxt;

	logic [15:0] crc_value;
	logic [15:0] seed_value;
	logic frame_bit;
	logic bit_step;
	logic bit_kept;
	logic par_err;
	logic crc_mismatch;
	logic [IRQ_W-1:0] irq_event;
	logic [IRQ_W-1:0] w1c_mask;
	logic wr_cfg;
	logic rd_hit;
	logic [DATA_W-1:0] rd_value;

	// Seed is resolved from the live configuration so the init at start sees fresh values
	assign seed_value = seed_lookup(st_r.cfg.seed_sel, st_r.cfg.custom_seed);

	assign bit_step = rx_bit.valid && (st_r.frame == FR_RECV);

	// Only bits after the first collision are affected; the colliding bit itself is kept
	assign bit_kept = (st_r.coll_seen && !st_r.snap.keep_after_coll) ? 1'b0 : rx_bit.data;
	assign frame_bit = bit_kept;

	rx_crc_unit u_crc (
		.sys_clk(sys_clk),
		.srst(srst),
		.init(rx_start),
		.seed(seed_value),
		.crc5(st_r.cfg.crc5),
		.step(bit_step && !crc_bit_is_parity()),
		.din(frame_bit),
		.crc(crc_value)
	);

	rx_byte_packer u_pack (
		.sys_clk(sys_clk),
		.srst(srst),
		.start(rx_start),
		.align(st_r.cfg.bit_align),
		.parity_en(st_r.snap.parity_en),
		.parity_odd(st_r.snap.parity_odd),
		.bit_valid(bit_step),
		.bit_data(frame_bit),
		.flush(rx_end && (st_r.frame == FR_RECV)),
		.byte_out(rx_byte),
		.parity_err(par_err)
	);

	// Mirror of the packer's parity slot so the CRC skips parity bits
	typedef struct packed {
		logic [2:0] pos;
		logic expect_par;
	} slot_s;

	slot_s slot_r;
	slot_s slot_nxt;

	function automatic logic crc_bit_is_parity();
		crc_bit_is_parity = slot_r.expect_par;
	endfunction : crc_bit_is_parity

	always_comb begin
		slot_nxt = slot_r;
		if (rx_start) begin
			slot_nxt.pos = st_r.cfg.bit_align;
			slot_nxt.expect_par = 1'b0;
		end else if (bit_step) begin
			if (slot_r.expect_par) begin
				slot_nxt.expect_par = 1'b0;
			end else if (slot_r.pos == 3'h7) begin
				slot_nxt.pos = 3'h0;
				slot_nxt.expect_par = st_r.snap.parity_en;
			end else begin
				slot_nxt.pos = slot_r.pos + 3'h1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			slot_r <= '0;
		end else begin
			slot_r <= slot_nxt;
		end
	end

	// Residue check; the 5-bit CRC compares only its own width
	always_comb begin
		if (st_r.snap.crc5) begin
			crc_mismatch = crc_value[4:0] !=
				(st_r.snap.rx_checksum_inverted ? CRC5_INV_RESIDUE : CRC5_RESIDUE);
		end else begin
			crc_mismatch = crc_value !=
				(st_r.snap.rx_checksum_inverted ? CRC16_INV_RESIDUE : CRC16_RESIDUE);
		end
	end

	assign wr_cfg = reg_wr && (reg_addr == CFG_ADDR);

	always_comb begin
		rd_hit = 1'b1;
		case (reg_addr)
			CFG_ADDR: rd_value = st_r.cfg & CFG_WRITABLE;
			IRQ_STAT_ADDR: rd_value = {{(DATA_W-IRQ_W){1'b0}}, st_r.irq_stat};
			IRQ_MASK_ADDR: rd_value = {{(DATA_W-IRQ_W){1'b0}}, st_r.irq_mask};
			CTRL_ADDR: rd_value = {31'h0000_0000, st_r.auto_detect_en};
			STATE_ADDR: rd_value = {crc_value, 11'h000, st_r.frame == FR_RECV, st_r.coll_seen,
				st_r.par_err_seen, st_r.crc_err, st_r.integrity};
			default: begin
				rd_hit = 1'b0;
				rd_value = 32'h0000_0000;
			end
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		irq_event = '0;
		w1c_mask = '0;

		// Read data stands only in the cycle after the strobe; unmapped reads return zero
		st_nxt.rdata = (reg_rd && rd_hit) ? rd_value : 32'h0000_0000;

		if (wr_cfg) begin
			st_nxt.cfg = cfg_s'(reg_wdata & CFG_WRITABLE);
		end
		if (reg_wr && (reg_addr == IRQ_MASK_ADDR)) begin
			st_nxt.irq_mask = reg_wdata[IRQ_W-1:0];
		end
		if (reg_wr && (reg_addr == CTRL_ADDR)) begin
			st_nxt.auto_detect_en = reg_wdata[0];
		end
		if (reg_wr && (reg_addr == IRQ_STAT_ADDR)) begin
			w1c_mask = reg_wdata[IRQ_W-1:0];
		end

		// Detector results win over a software write in the same cycle
		if (md_valid && st_r.auto_detect_en) begin
			irq_event[IRQ_MODE_LOADED] = 1'b1;
			case (md_mode)
				MD_ISO_A: begin
					st_nxt.cfg.parity_en = 1'b1;
					st_nxt.cfg.parity_odd = 1'b1;
					st_nxt.cfg.seed_sel = SEED_SEL_6363;
					st_nxt.cfg.rx_checksum_inverted = 1'b0;
				end
				MD_ISO_B: begin
					st_nxt.cfg.seed_sel = SEED_SEL_FFFF;
					st_nxt.cfg.rx_checksum_inverted = 1'b1;
					st_nxt.cfg.crc_en = 1'b1;
				end
				MD_JIS_212, MD_JIS_424: begin
					st_nxt.cfg.seed_sel = SEED_SEL_0000;
					st_nxt.cfg.rx_checksum_inverted = 1'b0;
					st_nxt.cfg.crc_en = 1'b1;
				end
				default: begin
					st_nxt.cfg = st_nxt.cfg;
				end
			endcase
		end

		case (st_r.frame)
			FR_IDLE: begin
				if (rx_start) begin
					st_nxt.frame = FR_RECV;
				end
			end
			FR_RECV: begin
				if (rx_bit.valid && rx_bit.coll && !st_r.coll_seen) begin
					st_nxt.coll_seen = 1'b1;
					irq_event[IRQ_COLLISION] = 1'b1;
				end
				if (rx_end) begin
					st_nxt.frame = FR_IDLE;
					irq_event[IRQ_FRAME_DONE] = 1'b1;
				end
			end
			default: begin
				st_nxt.frame = FR_IDLE;
			end
		endcase

		// A new reception snapshots the configuration and drops last frame's errors
		if (rx_start) begin
			st_nxt.snap = st_r.cfg;
			st_nxt.coll_seen = 1'b0;
			st_nxt.integrity = 1'b0;
			st_nxt.crc_err = 1'b0;
			st_nxt.par_err_seen = 1'b0;
		end

		// Error sets are applied last so they win over the clear at start
		if (par_err) begin
			st_nxt.par_err_seen = 1'b1;
			st_nxt.integrity = 1'b1;
		end
		if (rx_end && (st_r.frame == FR_RECV) && st_r.snap.crc_en && crc_mismatch) begin
			st_nxt.crc_err = 1'b1;
			st_nxt.integrity = 1'b1;
		end
		if (st_nxt.integrity && !st_r.integrity) begin
			irq_event[IRQ_INTEGRITY] = 1'b1;
		end

		st_nxt.irq_stat = (st_r.irq_stat & ~w1c_mask) | irq_event;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_r.cfg <= cfg_s'(CFG_RESET);
			st_r.snap <= cfg_s'(CFG_RESET);
			st_r.auto_detect_en <= 1'b0;
			st_r.irq_stat <= IRQ_RESET;
			st_r.irq_mask <= IRQ_RESET;
			st_r.rdata <= 32'h0000_0000;
			st_r.frame <= FR_IDLE;
			st_r.coll_seen <= 1'b0;
			st_r.integrity <= 1'b0;
			st_r.crc_err <= 1'b0;
			st_r.par_err_seen <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;
	assign integrity_error = st_r.integrity;
	assign crc_error = st_r.crc_err;
	assign irq = |(st_r.irq_stat & st_r.irq_mask);

endmodule : rx_crc_parity_check

/* File: design/rx_check_pkg.sv */
// Package: register map, field layouts, seeds and carriers of the receive check block
package rx_check_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Printed register indices; byte address is four times the index
	localparam logic [7:0] CFG_INDEX = 8'h12;
	localparam logic [7:0] IRQ_STAT_INDEX = 8'h20;
	localparam logic [7:0] IRQ_MASK_INDEX = 8'h21;
	localparam logic [7:0] CTRL_INDEX = 8'h22;
	localparam logic [7:0] STATE_INDEX = 8'h23;
	localparam logic [7:0] CFG_ADDR = {CFG_INDEX[5:0], 2'b00};
	localparam logic [7:0] IRQ_STAT_ADDR = {IRQ_STAT_INDEX[5:0], 2'b00};
	localparam logic [7:0] IRQ_MASK_ADDR = {IRQ_MASK_INDEX[5:0], 2'b00};
	localparam logic [7:0] CTRL_ADDR = {CTRL_INDEX[5:0], 2'b00};
	localparam logic [7:0] STATE_ADDR = {STATE_INDEX[5:0], 2'b00};

	// Configuration word, bit 31 first
	typedef struct packed {
		logic [15:0] custom_seed;
		logic [3:0] rsvd;
		logic parity_odd;
		logic parity_en;
		logic keep_after_coll;
		logic [2:0] bit_align;
		logic [2:0] seed_sel;
		logic crc5;
		logic rx_checksum_inverted;
		logic crc_en;
	} cfg_s;

	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] CFG_WRITABLE = 32'hffff_0fff;

	localparam logic [2:0] SEED_SEL_0000 = 3'h0;
	localparam logic [2:0] SEED_SEL_6363 = 3'h1;
	localparam logic [2:0] SEED_SEL_A671 = 3'h2;
	localparam logic [2:0] SEED_SEL_FFFF = 3'h3;
	localparam logic [2:0] SEED_SEL_0012 = 3'h4;
	localparam logic [2:0] SEED_SEL_E012 = 3'h5;
	localparam logic [2:0] SEED_SEL_RFU = 3'h6;
	localparam logic [2:0] SEED_SEL_CUSTOM = 3'h7;

	localparam logic [15:0] SEED_0000 = 16'h0000;
	localparam logic [15:0] SEED_6363 = 16'h6363;
	localparam logic [15:0] SEED_A671 = 16'ha671;
	localparam logic [15:0] SEED_FFFF = 16'hffff;
	localparam logic [15:0] SEED_0012 = 16'h0012;
	localparam logic [15:0] SEED_E012 = 16'he012;

	localparam logic [15:0] CRC16_POLY_REFL = 16'h8408;
	localparam logic [4:0] CRC5_POLY_REFL = 5'h12;
	localparam logic [15:0] CRC16_RESIDUE = 16'h0000;
	localparam logic [15:0] CRC16_INV_RESIDUE = 16'hf0b8;
	localparam logic [4:0] CRC5_RESIDUE = 5'h00;
	localparam logic [4:0] CRC5_INV_RESIDUE = 5'h00;

	localparam int IRQ_W = 4;
	localparam int IRQ_FRAME_DONE = 0;
	localparam int IRQ_INTEGRITY = 1;
	localparam int IRQ_COLLISION = 2;
	localparam int IRQ_MODE_LOADED = 3;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

	typedef enum logic [1:0] {
		MD_ISO_A = 2'b00,
		MD_ISO_B = 2'b01,
		MD_JIS_212 = 2'b10,
		MD_JIS_424 = 2'b11
	} md_mode_e;

	typedef enum logic [1:0] {
		FR_IDLE = 2'b00,
		FR_RECV = 2'b01
	} frame_e;

	typedef struct packed {
		logic valid;
		logic data;
		logic coll;
	} rx_bit_s;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic [2:0] last_bits;
		logic last;
	} rx_byte_s;

	localparam rx_byte_s RX_BYTE_IDLE = '{valid: 1'b0, data: 8'h00, last_bits: 3'h0, last: 1'b0};

	function automatic logic [15:0] seed_lookup(input logic [2:0] sel, input logic [15:0] custom);
		case (sel)
			SEED_SEL_0000: seed_lookup = SEED_0000;
			SEED_SEL_6363: seed_lookup = SEED_6363;
			SEED_SEL_A671: seed_lookup = SEED_A671;
			SEED_SEL_FFFF: seed_lookup = SEED_FFFF;
			SEED_SEL_0012: seed_lookup = SEED_0012;
			SEED_SEL_E012: seed_lookup = SEED_E012;
			SEED_SEL_CUSTOM: seed_lookup = custom;
			default: seed_lookup = SEED_0000;
		endcase
	endfunction : seed_lookup

endpackage : rx_check_pkg

/* File: design/rx_crc_unit.sv */
// Bitwise receive CRC register, 16-bit or 5-bit, least significant bit first
`timescale 1ns/100ps
module rx_crc_unit (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic init,
	input wire logic [15:0] seed,
	input wire logic crc5,
	input wire logic step,
	input wire logic din,
	output logic [15:0] crc
);
	import rx_check_pkg::*;

	typedef struct packed {
		logic [15:0] crc;
	} crc_state_s;

	crc_state_s st_r;
	crc_state_s st_nxt;

	function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic d);
		crc16_step = (c >> 1) ^ ((c[0] ^ d) ? CRC16_POLY_REFL : 16'h0000);
	endfunction : crc16_step

	function automatic logic [4:0] crc5_step(input logic [4:0] c, input logic d);
		crc5_step = (c >> 1) ^ ((c[0] ^ d) ? CRC5_POLY_REFL : 5'h00);
	endfunction : crc5_step

	always_comb begin
		st_nxt = st_r;
		if (init) begin
			st_nxt.crc = crc5 ? {8'h00, seed[7:0]} : seed;
		end else if (step) begin
			if (crc5) begin
				st_nxt.crc = {11'h000, crc5_step(st_r.crc[4:0], din)};
			end else begin
				st_nxt.crc = crc16_step(st_r.crc, din);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign crc = st_r.crc;

endmodule : rx_crc_unit

/* File: design/rx_byte_packer.sv */
// Packs received bits into bytes from the aligned position and checks per-byte parity
`timescale 1ns/100ps
module rx_byte_packer (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic start,
	input wire logic [2:0] align,
	input wire logic parity_en,
	input wire logic parity_odd,
	input wire logic bit_valid,
	input wire logic bit_data,
	input wire logic flush,
	output rx_check_pkg::rx_byte_s byte_out,
	output logic parity_err
);
	import rx_check_pkg::*;

	typedef struct packed {
		logic [2:0] pos;
		logic [2:0] base;
		logic [7:0] shreg;
		logic expect_par;
		logic par_acc;
		rx_byte_s out;
		logic perr;
	} pack_state_s;

	pack_state_s st_r;
	pack_state_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.out = RX_BYTE_IDLE;
		st_nxt.perr = 1'b0;
		if (start) begin
			st_nxt.pos = align;
			st_nxt.base = align;
			st_nxt.shreg = 8'h00;
			st_nxt.expect_par = 1'b0;
			st_nxt.par_acc = 1'b0;
		end else if (bit_valid) begin
			if (st_r.expect_par) begin
				// Parity bit is consumed here and never reaches the byte stream
				st_nxt.perr = (st_r.par_acc ^ bit_data) != parity_odd;
				st_nxt.expect_par = 1'b0;
				st_nxt.par_acc = 1'b0;
			end else begin
				st_nxt.shreg[st_r.pos] = bit_data;
				st_nxt.par_acc = st_r.par_acc ^ bit_data;
				if (st_r.pos == 3'h7) begin
					st_nxt.out = '{valid: 1'b1, data: st_nxt.shreg, last_bits: 3'h0, last: 1'b0};
					st_nxt.shreg = 8'h00;
					st_nxt.pos = 3'h0;
					st_nxt.base = 3'h0;
					st_nxt.expect_par = parity_en;
				end else begin
					st_nxt.pos = st_r.pos + 3'h1;
				end
			end
		end else if (flush && (st_r.pos != st_r.base)) begin
			// Partial last byte; last_bits counts valid positions from bit 0
			st_nxt.out = '{valid: 1'b1, data: st_r.shreg, last_bits: st_r.pos, last: 1'b1};
			st_nxt.shreg = 8'h00;
			st_nxt.base = st_r.pos;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign byte_out = st_r.out;
	assign parity_err = st_r.perr;

endmodule : rx_byte_packer

/* File: bench/rx_crc_parity_check_sva.sv */
// Port-level checks of the receive check block
`timescale 1ns/100ps
module rx_crc_parity_check_sva (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [rx_check_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [rx_check_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [rx_check_pkg::DATA_W-1:0] reg_rdata,
	input wire logic rx_start,
	input wire logic rx_end,
	input wire rx_check_pkg::rx_bit_s rx_bit,
	input wire logic md_valid,
	input wire rx_check_pkg::md_mode_e md_mode,
	input wire rx_check_pkg::rx_byte_s rx_byte,
	input wire logic integrity_error,
	input wire logic crc_error,
	input wire logic irq
);
	import rx_check_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == '0)
		else $error("read data not zero after idle cycle");
	cfg_rsvd_zero_a: assert property (reg_rd && reg_addr == CFG_ADDR |=> reg_rdata[15:12] == 4'h0)
		else $error("reserved config bits not zero");
	cfg_write_back_a: assert property ((reg_wr && reg_addr == CFG_ADDR && !md_valid)
		##1 (reg_rd && reg_addr == CFG_ADDR && !md_valid)
		|=> reg_rdata == ($past(reg_wdata, 2) & 32'hffff_0fff))
		else $error("config read back differs from write");
	integ_clear_a: assert property (rx_start && !$past(rx_end) && !$past(rx_bit.valid)
		&& !$past(rx_bit.valid, 2) |=> !integrity_error)
		else $error("integrity flag kept over new reception");
	crc_sets_integ_a: assert property ($rose(crc_error) |-> integrity_error)
		else $error("checksum error without integrity flag");
	crc_rise_cause_a: assert property ($rose(crc_error) |-> $past(rx_end))
		else $error("checksum error outside frame end");
	crc_fall_cause_a: assert property ($fell(crc_error) |-> $past(rx_start))
		else $error("checksum error dropped without new frame");
	integ_rise_cause_a: assert property ($rose(integrity_error) |-> $past(rx_end)
		|| $past(rx_bit.valid, 2) || $past(rx_bit.valid, 3))
		else $error("integrity flag rose without cause");
	byte_cause_a: assert property (rx_byte.valid |-> $past(rx_bit.valid) || $past(rx_end))
		else $error("byte emitted without a bit");
	mask_off_irq_a: assert property (reg_wr && reg_addr == IRQ_MASK_ADDR && reg_wdata == '0
		|=> !irq)
		else $error("interrupt high with mask cleared");
endmodule : rx_crc_parity_check_sva

/* File: bench/rx_frame_source.sv */
// Far-side model: demodulated card bit stream framed by start and end pulses
`timescale 1ns/100ps
module rx_frame_source (
	output logic rx_start,
	output logic rx_end,
	output rx_check_pkg::rx_bit_s rx_bit,
	input wire logic sys_clk
);
	import rx_check_pkg::*;
	initial begin
		rx_start = 1'b0;
		rx_end = 1'b0;
		rx_bit = '0;
	end
	// Data toggles between bits so sampling without valid picks up garbage
	task automatic send(input bit b[$], input int coll_at, input int gap);
		@(posedge sys_clk);
		rx_start <= 1'b1;
		@(posedge sys_clk);
		rx_start <= 1'b0;
		foreach (b[i]) begin
			rx_bit <= '{valid: 1'b1, data: b[i], coll: i == coll_at};
			repeat (gap) begin
				@(posedge sys_clk);
				rx_bit <= '{valid: 1'b0, data: ~rx_bit.data, coll: 1'b0};
			end
			@(posedge sys_clk);
		end
		rx_bit <= '{valid: 1'b0, data: ~rx_bit.data, coll: 1'b0};
		rx_end <= 1'b1;
		@(posedge sys_clk);
		rx_end <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask : send
endmodule : rx_frame_source

/* File: bench/rx_crc_parity_check_tb_top.sv */
// Self-checking bench of the receive check block
`timescale 1ns/100ps
module rx_crc_parity_check_tb_top;
	import rx_check_pkg::*;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic rx_start, rx_end, md_valid = 1'b0, integrity_error, crc_error, irq;
	rx_bit_s rx_bit;
	md_mode_e md_mode = MD_ISO_A;
	rx_byte_s rx_byte;
	int n_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [31:0] rnd = 32'h98c6;
	logic [31:0] rdv;
	logic [15:0] seed, crcv;
	bit bad;
	logic [7:0] got[$], exp_q[$];
	bit fbits[$], dbits[$];
	logic [15:0] seeds[8] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff, 16'h0012, 16'he012,
		16'h0000, 16'h0000};
	logic [31:0] md_cfg[4] = '{32'h0c08, 32'h001b, 32'h0001, 32'h0001};

	always #2.5 sys_clk = ~sys_clk;

	rx_crc_parity_check u_dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_start(rx_start), .rx_end(rx_end), .rx_bit(rx_bit), .md_valid(md_valid),
		.md_mode(md_mode), .rx_byte(rx_byte), .integrity_error(integrity_error),
		.crc_error(crc_error), .irq(irq));
	rx_frame_source u_src (.rx_start(rx_start), .rx_end(rx_end), .rx_bit(rx_bit),
		.sys_clk(sys_clk));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [4:0] crc5(input logic [4:0] s);
		foreach (dbits[i]) s = (s[0] ^ dbits[i]) ? ((s >> 1) ^ 5'h12) : (s >> 1);
		return s;
	endfunction : crc5
	function automatic logic [15:0] crc16(input logic [15:0] s);
		foreach (dbits[i]) s = (s[0] ^ dbits[i]) ? ((s >> 1) ^ 16'h8408) : (s >> 1);
		return s;
	endfunction : crc16
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, want, seen);
		end
	endtask : chk
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
	endtask : bus
	task automatic rd(input logic [7:0] a);
		bus(1'b0, 1'b1, a, '0);
		bus(1'b0, 1'b0, '0, '0);
		#1;
		rdv = reg_rdata;
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, 1'b0, a, d);
		bus(1'b0, 1'b0, '0, '0);
		#1;
	endtask : wr
	task automatic put_byte(input logic [7:0] b, input bit par, input bit odd_p, input bit flip);
		for (int i = 0; i < 8; i++) begin
			fbits.push_back(b[i]);
			dbits.push_back(b[i]);
		end
		if (par) fbits.push_back(^b ^ odd_p ^ flip);
	endtask : put_byte
	// Expected bytes follow from data bits only, so parity stripping is checked too
	task automatic run(input int align, input int coll, input bit keep, input int gap);
		int pos;
		int base;
		logic [7:0] acc;
		pos = align;
		base = align;
		acc = 8'h00;
		exp_q.delete();
		got.delete();
		foreach (dbits[j]) begin
			acc[pos] = (keep || coll < 0 || j <= coll) ? dbits[j] : 1'b0;
			pos++;
			if (pos == 8) begin
				exp_q.push_back(acc);
				acc = 8'h00;
				pos = 0;
				base = 0;
			end
		end
		// A partial final byte is flushed at frame end
		if (pos != base) exp_q.push_back(acc);
		u_src.send(fbits, coll, gap);
		chk("byte count", got.size(), exp_q.size());
		foreach (exp_q[i]) chk("byte", got[i], exp_q[i]);
		fbits.delete();
		dbits.delete();
	endtask : run
	task automatic finish_test;
		$display("Checks %0d, errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test

	always @(posedge sys_clk) begin
		if (rx_byte.valid === 1'b1) got.push_back(rx_byte.data);
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			finish_test();
		end
	end

	initial begin
		repeat (20) @(posedge sys_clk);
		srst <= 1'b0;
		rd(CFG_ADDR);
		chk("cfg reset", rdv, 32'h0);
		bus(1'b1, 1'b0, CFG_ADDR, 32'hffff_ffff);
		rd(CFG_ADDR);
		chk("cfg bits", rdv, 32'hffff_0fff);
		rd(8'h04);
		chk("unmapped", rdv, 32'h0);
		for (int i = 0; i < 17; i++) begin
			rnd = lfsr(rnd);
			seed = (i[2:0] == 3'h7) ? rnd[31:16] : seeds[i[2:0]];
			wr(CFG_ADDR, {rnd[31:16], 10'h0, i[2:0], 1'b0, i[3], i < 16});
			for (int k = 0; k < 3; k++) put_byte(rnd[8*k +: 8], 1'b0, 1'b0, 1'b0);
			crcv = crc16(seed);
			if (i[3]) crcv = ~crcv;
			put_byte(crcv[7:0], 1'b0, 1'b0, 1'b0);
			put_byte(crcv[15:8], 1'b0, 1'b0, 1'b0);
			bad = i[0] || i == 16;
			if (bad) begin
				fbits[5] = ~fbits[5];
				dbits[5] = ~dbits[5];
			end
			run(0, -1, 1'b1, i % 3);
			chk("crc error", crc_error, bad && i < 16);
			chk("crc integrity", integrity_error, bad && i < 16);
		end
		for (int b = 0; b < 2; b++) begin
			rnd = lfsr(rnd);
			seed = rnd[31:16];
			wr(CFG_ADDR, {rnd[31:16], 10'h0, 3'h7, 1'b1, 1'b0, 1'b1});
			for (int k = 0; k < 2; k++) put_byte(rnd[8*k +: 8], 1'b0, 1'b0, 1'b0);
			crcv = {11'h000, crc5(seed[4:0])};
			for (int k = 0; k < 5; k++) begin
				fbits.push_back(crcv[k]);
				dbits.push_back(crcv[k]);
			end
			if (b == 1) begin
				fbits[5] = ~fbits[5];
				dbits[5] = ~dbits[5];
			end
			run(0, -1, 1'b1, 0);
			chk("crc5 error", crc_error, b[0]);
			chk("crc5 integrity", integrity_error, b[0]);
		end
		for (int p = 0; p < 2; p++) begin
			wr(CFG_ADDR, {20'h0, p[0], 1'b1, 10'h0});
			rnd = lfsr(rnd);
			for (int k = 0; k < 3; k++) put_byte(rnd[8*k +: 8], 1'b1, p[0], p == 1 && k == 1);
			run(0, -1, 1'b1, 0);
			chk("parity integrity", integrity_error, p[0]);
			chk("parity crc", crc_error, 1'b0);
		end
		wr(IRQ_STAT_ADDR, 32'hf);
		wr(IRQ_MASK_ADDR, 32'hf);
		chk("irq idle", irq, 1'b0);
		for (int c = 0; c < 2; c++) begin
			wr(CFG_ADDR, {22'h0, c[0], 3'h3, 6'h0});
			rnd = lfsr(rnd);
			for (int j = 0; j < 13; j++) begin
				fbits.push_back(rnd[j]);
				dbits.push_back(rnd[j]);
			end
			run(3, 6, c[0], 1);
			chk("irq raised", irq, 1'b1);
			wr(IRQ_STAT_ADDR, 32'hf);
			chk("irq cleared", irq, 1'b0);
		end
		wr(CTRL_ADDR, 32'h1);
		for (int m = 0; m < 4; m++) begin
			wr(CFG_ADDR, 32'h0);
			@(posedge sys_clk);
			md_valid <= 1'b1;
			md_mode <= md_mode_e'(m);
			@(posedge sys_clk);
			md_valid <= 1'b0;
			rd(CFG_ADDR);
			chk("mode load", rdv, md_cfg[m]);
		end
		chk("irq mode", irq, 1'b1);
		wr(IRQ_MASK_ADDR, 32'h0);
		chk("irq masked", irq, 1'b0);
		finish_test();
	end
endmodule : rx_crc_parity_check_tb_top

bind rx_crc_parity_check rx_crc_parity_check_sva u_sva (.sys_clk(sys_clk), .srst(srst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .rx_start(rx_start), .rx_end(rx_end), .rx_bit(rx_bit),
	.md_valid(md_valid), .md_mode(md_mode), .rx_byte(rx_byte),
	.integrity_error(integrity_error), .crc_error(crc_error), .irq(irq));
